// ===== mac_dma_buf.sv
`timescale 1ns/1ps
`default_nettype none

package mac_dma_pkg;
	// receive status word fields
	localparam int OWN_BIT = 31;
	localparam int FIRST_BIT = 30;
	localparam int LAST_BIT = 29;
	localparam int ERR_SUM_BIT = 25;
	localparam int MCAST_BIT = 24;
	localparam int PORT1_BIT = 20;
	localparam int PORT2_BIT = 21;
	localparam int PHY_ERR_BIT = 19;
	localparam int OVERSIZE_BIT = 18;
	localparam int RUNT_BIT = 17;
	localparam int CRC_BIT = 16;
	localparam int ETYPE_BIT = 15;
	localparam int LEN_MSB = 10;
	// receive control word fields
	localparam int WRAP_BIT = 25;
	localparam int SIZE_MSB = 11;
	// byte offsets of the descriptor words
	localparam logic [31:0] CTRL_OFS = 32'h0000_0004;
	localparam logic [31:0] BUFP_OFS = 32'h0000_0008;
	localparam logic [31:0] LINK_OFS = 32'h0000_000C;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [11:0] WORD_BYTES12 = 12'h004;
	// frame limits
	localparam logic [10:0] MAX_FRAME_LEN = 11'h5EE;
	localparam logic [15:0] MAX_LEN_FIELD = 16'h05DC;
	// buffered word: {phy, last, crc, runt, mcast, port[1:0], len, etype, data}
	localparam int PAYLOAD_W = 51;
	localparam int RESET_CUR = 0;

	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_FETCH0 = 10'h002,
		ST_FETCH1 = 10'h004,
		ST_FETCH2 = 10'h008,
		ST_FETCH3 = 10'h010,
		ST_DATA = 10'h020,
		ST_WRITE = 10'h040,
		ST_CLOSE = 10'h080,
		ST_TXCLR = 10'h100,
		ST_SUSP = 10'h200
	} dma_state_t;
endpackage

module rx_word_buffer #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} buf_state_t;

	buf_state_t q;
	buf_state_t d;
	logic push;
	logic pop;

	// handshakes straight from the fill count
	assign in_ready = (q.cnt != (PW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointers wrap at depth, count tracks the difference
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
		end
		d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	chk_no_overflow: assert property (@(posedge clk) disable iff (rst)
		q.cnt <= (PW+1)'(DEPTH)) else $error("word buffer overflow");
endmodule // rx_word_buffer

`default_nettype wire

// ===== mac_dma_desc.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - error summary ORs crc, oversize, runt
// - multicast flag set for multicast frames
// - source port field bit20 port1, bit21 port2
// - phy receive error seen anywhere sets flag
// - oversize flag when length exceeds 1518
// - oversize frames delivered whole, never truncated
// - runt flagged, dropped unless pass-bad set
// - crc error flag bit 16
// - ethertype flag when length field above 1500, except on runts
// - byte count including crc in bits 10-0
// - ring wrap bit returns to list base
// - buffer size field; zero skips descriptor
// - next descriptor fetched from link word
// - device clears transmit ownership when done
// - receive ownership cleared on completion or full
// - first buffer flag in frame's first descriptor
// - last buffer flag in frame's final descriptor
module mac_dma_desc (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic RX_ENABLE,
	input wire logic [31:0] RX_LIST_BASE,
	input wire logic RX_POLL,
	input wire logic PASS_BAD_FRAMES,
	output logic RX_SUSPENDED,
	output logic RX_FRAME_DONE,
	input wire logic RX_VALID,
	output logic RX_READY,
	input wire logic [31:0] RX_DATA,
	input wire logic RX_LAST,
	input wire logic RX_PHY_ERR,
	input wire logic RX_CRC_ERR,
	input wire logic RX_RUNT,
	input wire logic RX_MCAST,
	input wire logic [1:0] RX_PORT,
	input wire logic [10:0] RX_LEN,
	input wire logic [15:0] RX_TYPE_LEN,
	input wire logic TX_RELEASE,
	input wire logic [31:0] TX_RELEASE_ADDR,
	output logic TX_RELEASE_READY,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [31:0] MEM_WDATA,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_ACK
);
	typedef struct packed {
		mac_dma_pkg::dma_state_t st;
		logic [31:0] cur_addr;
		logic wrap;
		logic [11:0] left;
		logic [31:0] buf_ptr;
		logic [31:0] next_ptr;
		logic first;
		logic phy_acc;
		logic last_seen;
		logic close_last;
		logic [10:0] len;
		logic crc;
		logic runt;
		logic mcast;
		logic [1:0] port;
		logic etype;
		logic tx_pend;
		logic [31:0] tx_addr;
		logic [31:0] addr_r;
		logic [31:0] wdata_r;
		logic we_r;
		logic done_r;
	} dma_regs_t;

	dma_regs_t q;
	dma_regs_t d;
	logic [mac_dma_pkg::PAYLOAD_W-1:0] in_word;
	logic [mac_dma_pkg::PAYLOAD_W-1:0] head;
	logic head_valid;
	logic head_ready;
	logic etype_in;

	// next descriptor: list base after the ring end, else the link word
	function automatic logic [31:0] next_desc(input logic wrap,
		input logic [31:0] base, input logic [31:0] link);
		next_desc = wrap ? base : link;
	endfunction

	// status word written back; ownership always returned to the host
	function automatic logic [31:0] status_word(input dma_regs_t s,
		input logic ls);
		logic oversize;
		oversize = (s.len > mac_dma_pkg::MAX_FRAME_LEN);
		status_word = '0;
		status_word[mac_dma_pkg::OWN_BIT] = 1'b0;
		status_word[mac_dma_pkg::FIRST_BIT] = s.first;
		status_word[mac_dma_pkg::LAST_BIT] = ls;
		status_word[mac_dma_pkg::PHY_ERR_BIT] = s.phy_acc;
		if (ls) begin
			status_word[mac_dma_pkg::ERR_SUM_BIT] =
				s.crc | oversize | s.runt;
			status_word[mac_dma_pkg::MCAST_BIT] = s.mcast;
			status_word[mac_dma_pkg::PORT1_BIT] = s.port[0];
			status_word[mac_dma_pkg::PORT2_BIT] = s.port[1];
			status_word[mac_dma_pkg::OVERSIZE_BIT] = oversize;
			status_word[mac_dma_pkg::RUNT_BIT] = s.runt;
			status_word[mac_dma_pkg::CRC_BIT] = s.crc;
			status_word[mac_dma_pkg::ETYPE_BIT] = s.etype & ~s.runt;
			status_word[mac_dma_pkg::LEN_MSB:0] = s.len;
		end
	endfunction

	// frame type decided on entry; meaningless for runts, masked later
	assign etype_in = (RX_TYPE_LEN > mac_dma_pkg::MAX_LEN_FIELD);
	assign in_word = {RX_PHY_ERR, RX_LAST, RX_CRC_ERR, RX_RUNT, RX_MCAST,
		RX_PORT, RX_LEN, etype_in, RX_DATA};

	// two words of slack so a slow memory grant never drops receive data
	rx_word_buffer #(
		.W(mac_dma_pkg::PAYLOAD_W),
		.DEPTH(2)
	) u_rx_buf (
		.clk(REF_CLK),
		.rst(RST),
		.in_valid(RX_VALID),
		.in_ready(RX_READY),
		.in_data(in_word),
		.out_valid(head_valid),
		.out_ready(head_ready),
		.out_data(head)
	);

	// memory request is a handshake held until the grant
	assign MEM_REQ = (q.st == mac_dma_pkg::ST_FETCH0) ||
		(q.st == mac_dma_pkg::ST_FETCH1) ||
		(q.st == mac_dma_pkg::ST_FETCH2) ||
		(q.st == mac_dma_pkg::ST_FETCH3) ||
		(q.st == mac_dma_pkg::ST_WRITE) ||
		(q.st == mac_dma_pkg::ST_CLOSE) ||
		(q.st == mac_dma_pkg::ST_TXCLR);
	assign MEM_WE = q.we_r;
	assign MEM_ADDR = q.addr_r;
	assign MEM_WDATA = q.wdata_r;
	assign head_ready = (q.st == mac_dma_pkg::ST_DATA);
	assign RX_SUSPENDED = (q.st == mac_dma_pkg::ST_SUSP);
	assign RX_FRAME_DONE = q.done_r;
	assign TX_RELEASE_READY = !q.tx_pend;

	// descriptor walk, data copy and status write-back
	always_comb begin
		d = q;
		d.done_r = 1'b0;
		// one pending release; ready low while held, so no set/clear clash
		if (TX_RELEASE && !q.tx_pend) begin
			d.tx_pend = 1'b1;
			d.tx_addr = TX_RELEASE_ADDR;
		end
		case (q.st)
			mac_dma_pkg::ST_IDLE: begin
				if (q.tx_pend) begin
					d.addr_r = q.tx_addr;
					d.wdata_r = '0;
					d.we_r = 1'b1;
					d.st = mac_dma_pkg::ST_TXCLR;
				end else if (RX_ENABLE) begin
					d.addr_r = q.cur_addr;
					d.we_r = 1'b0;
					d.st = mac_dma_pkg::ST_FETCH0;
				end
			end
			mac_dma_pkg::ST_FETCH0: begin
				if (MEM_ACK) begin
					if (MEM_RDATA[mac_dma_pkg::OWN_BIT]) begin
						d.addr_r = q.cur_addr + mac_dma_pkg::CTRL_OFS;
						d.st = mac_dma_pkg::ST_FETCH1;
					end else begin
						d.st = mac_dma_pkg::ST_SUSP;
					end
				end
			end
			mac_dma_pkg::ST_FETCH1: begin
				if (MEM_ACK) begin
					d.wrap = MEM_RDATA[mac_dma_pkg::WRAP_BIT];
					d.left = MEM_RDATA[mac_dma_pkg::SIZE_MSB:0];
					d.addr_r = q.cur_addr + mac_dma_pkg::BUFP_OFS;
					d.st = mac_dma_pkg::ST_FETCH2;
				end
			end
			mac_dma_pkg::ST_FETCH2: begin
				if (MEM_ACK) begin
					d.buf_ptr = MEM_RDATA;
					d.addr_r = q.cur_addr + mac_dma_pkg::LINK_OFS;
					d.st = mac_dma_pkg::ST_FETCH3;
				end
			end
			mac_dma_pkg::ST_FETCH3: begin
				if (MEM_ACK) begin
					d.next_ptr = MEM_RDATA;
					if (q.left == '0) begin
						// empty buffer: pass over, ownership untouched
						d.cur_addr = next_desc(q.wrap, RX_LIST_BASE,
							MEM_RDATA);
						d.st = mac_dma_pkg::ST_IDLE;
					end else begin
						d.st = mac_dma_pkg::ST_DATA;
					end
				end
			end
			mac_dma_pkg::ST_DATA: begin
				if (head_valid) begin
					d.addr_r = q.buf_ptr;
					d.wdata_r = head[31:0];
					d.we_r = 1'b1;
					d.etype = head[32];
					d.len = head[43:33];
					d.port = head[45:44];
					d.mcast = head[46];
					d.runt = head[47];
					d.crc = head[48];
					d.last_seen = head[49];
					d.phy_acc = q.phy_acc | head[50];
					d.st = mac_dma_pkg::ST_WRITE;
				end
			end
			mac_dma_pkg::ST_WRITE: begin
				if (MEM_ACK) begin
					d.buf_ptr = q.buf_ptr + mac_dma_pkg::WORD_BYTES;
					d.left = (q.left > mac_dma_pkg::WORD_BYTES12) ?
						q.left - mac_dma_pkg::WORD_BYTES12 : '0;
					if (q.last_seen && q.runt && !PASS_BAD_FRAMES) begin
						// discard: descriptor kept and refilled by the next frame
						d.first = 1'b1;
						d.phy_acc = 1'b0;
						d.st = mac_dma_pkg::ST_IDLE;
					end else if (q.last_seen) begin
						d.close_last = 1'b1;
						d.addr_r = q.cur_addr;
						d.wdata_r = status_word(q, 1'b1);
						d.st = mac_dma_pkg::ST_CLOSE;
					end else if (q.left <= mac_dma_pkg::WORD_BYTES12) begin
						// buffer full mid-frame; frame continues whole in next
						d.close_last = 1'b0;
						d.addr_r = q.cur_addr;
						d.wdata_r = status_word(q, 1'b0);
						d.st = mac_dma_pkg::ST_CLOSE;
					end else begin
						d.st = mac_dma_pkg::ST_DATA;
					end
				end
			end
			mac_dma_pkg::ST_CLOSE: begin
				if (MEM_ACK) begin
					d.cur_addr = next_desc(q.wrap, RX_LIST_BASE,
						q.next_ptr);
					d.first = q.close_last;
					d.we_r = 1'b0;
					if (q.close_last) begin
						d.phy_acc = 1'b0;
						d.done_r = 1'b1;
					end
					d.st = mac_dma_pkg::ST_IDLE;
				end
			end
			mac_dma_pkg::ST_TXCLR: begin
				if (MEM_ACK) begin
					d.tx_pend = 1'b0;
					d.we_r = 1'b0;
					d.st = mac_dma_pkg::ST_IDLE;
				end
			end
			mac_dma_pkg::ST_SUSP: begin
				// wait for the host to hand the descriptor back
				if (RX_POLL || q.tx_pend) begin
					d.st = mac_dma_pkg::ST_IDLE;
				end
			end
			default: begin
				d.st = mac_dma_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.st <= mac_dma_pkg::ST_IDLE;
			q.first <= 1'b1;
		end else begin
			q <= d;
		end
	end

	chk_err_summary: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE && q.close_last) |->
		MEM_WDATA[mac_dma_pkg::ERR_SUM_BIT] ==
		(MEM_WDATA[mac_dma_pkg::CRC_BIT] |
		MEM_WDATA[mac_dma_pkg::OVERSIZE_BIT] |
		MEM_WDATA[mac_dma_pkg::RUNT_BIT]))
		else $error("error summary mismatch");

	chk_oversize_len: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE && q.close_last) |->
		MEM_WDATA[mac_dma_pkg::OVERSIZE_BIT] ==
		(MEM_WDATA[10:0] > mac_dma_pkg::MAX_FRAME_LEN))
		else $error("oversize flag mismatch");

	chk_etype_runt: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE && MEM_WDATA[mac_dma_pkg::RUNT_BIT])
		|-> !MEM_WDATA[mac_dma_pkg::ETYPE_BIT])
		else $error("frame type set on runt");

	chk_own_return: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE || q.st == mac_dma_pkg::ST_TXCLR) |->
		MEM_REQ && MEM_WE && !MEM_WDATA[mac_dma_pkg::OWN_BIT])
		else $error("ownership not returned");

	chk_host_owned: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_FETCH0 && MEM_ACK &&
		!MEM_RDATA[mac_dma_pkg::OWN_BIT]) |=> RX_SUSPENDED ##1
		(RX_SUSPENDED || $past(RX_POLL) || $past(q.tx_pend)))
		else $error("host-owned descriptor used");

	chk_ring_wrap: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE && MEM_ACK && q.wrap) |=>
		q.cur_addr == $past(RX_LIST_BASE))
		else $error("ring end not wrapped");

	chk_next_link: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE && MEM_ACK && !q.wrap) |=>
		q.cur_addr == $past(q.next_ptr))
		else $error("next descriptor not followed");

	chk_zero_skip: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_FETCH3 && MEM_ACK && q.left == 12'h000) |=>
		q.st == mac_dma_pkg::ST_IDLE ##1
		q.st != mac_dma_pkg::ST_DATA)
		else $error("empty buffer not skipped");

	chk_first_flag: assert property (@(posedge REF_CLK) disable iff (RST)
		(q.st == mac_dma_pkg::ST_CLOSE && MEM_ACK) |=>
		q.first == $past(q.close_last) && RX_FRAME_DONE ==
		$past(q.close_last))
		else $error("first flag tracking wrong");
endmodule // mac_dma_desc

`default_nettype wire

// ===== host_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] lat,
	input wire logic req,
	input wire logic we,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata,
	output logic ack
);
	logic [31:0] mem [logic [31:0]];
	logic [1:0] cnt_r;

	// grant after lat waiting cycles; plain always so the bench may preload
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
			cnt_r <= 2'h0;
			rdata <= 32'h0;
		end else begin
			ack <= 1'b0;
			// read data toggles outside a grant so stale words never look valid
			rdata <= ~rdata;
			if (req && !ack) begin
				if (cnt_r == lat) begin
					ack <= 1'b1;
					cnt_r <= 2'h0;
					rdata <= mem.exists(addr) ? mem[addr] : ~addr;
				end else begin
					cnt_r <= cnt_r + 2'h1;
				end
			end
			// blocking store: grant and store never share one edge
			if (req && ack && we) begin
				mem[addr] = wdata;
			end
		end
	end
endmodule // host_mem_model

`default_nettype wire

// ===== mac_dma_descriptor_fields_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module mac_dma_descriptor_fields_bench;
	logic ref_clk, rst, rx_enable, rx_poll, pass_bad, rx_susp, rx_done;
	logic rx_valid, rx_ready, rx_last, rx_phy, rx_crc, rx_runt, rx_mcast;
	logic tx_rel, tx_ready, mem_req, mem_we, mem_ack;
	logic [1:0] rx_port, lat;
	logic [10:0] rx_len;
	logic [15:0] rx_type;
	logic [31:0] rx_data, tx_addr, mem_addr, mem_wdata, mem_rdata;
	int n_errors = 0;
	int checks_done = 0;

	mac_dma_desc u_dut (.REF_CLK(ref_clk), .RST(rst), .RX_ENABLE(rx_enable),
		.RX_LIST_BASE(32'h0000_0500), .RX_POLL(rx_poll),
		.PASS_BAD_FRAMES(pass_bad), .RX_SUSPENDED(rx_susp),
		.RX_FRAME_DONE(rx_done), .RX_VALID(rx_valid), .RX_READY(rx_ready),
		.RX_DATA(rx_data), .RX_LAST(rx_last), .RX_PHY_ERR(rx_phy),
		.RX_CRC_ERR(rx_crc), .RX_RUNT(rx_runt), .RX_MCAST(rx_mcast),
		.RX_PORT(rx_port), .RX_LEN(rx_len), .RX_TYPE_LEN(rx_type),
		.TX_RELEASE(tx_rel), .TX_RELEASE_ADDR(tx_addr),
		.TX_RELEASE_READY(tx_ready), .MEM_REQ(mem_req), .MEM_WE(mem_we),
		.MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
		.MEM_ACK(mem_ack));

	host_mem_model u_host (.clk(ref_clk), .rst(rst), .lat(lat), .req(mem_req),
		.we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata),
		.ack(mem_ack));

	// free-running 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic wrap_up;
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// host lays descriptors word aligned, sizes in whole words, owner set
	// ownership word goes last so a fetch never sees a half-built entry
	task automatic desc(input logic [31:0] a, c, b, l);
		u_host.mem[a + 32'h4] = c;
		u_host.mem[a + 32'h8] = b;
		u_host.mem[a + 32'hC] = l;
		u_host.mem[a] = 32'h8000_0000;
	endtask

	// bounded wait: 0 frame done, 1 suspended, 2 release ready
	task automatic wait_for(input int k);
		for (int n = 0; n < 500; n++) begin
			if ((k == 0 && rx_done === 1'b1) || (k == 1 && rx_susp === 1'b1) ||
				(k == 2 && tx_ready === 1'b1))
				return;
			@(posedge ref_clk);
			#1;
		end
		n_errors++;
		wrap_up();
	endtask

	// valid stays up between words, so callers drop it after the last one
	task automatic put(input logic [31:0] d, input logic last, phy);
		logic ok;
		rx_valid = 1'b1;
		rx_data = d;
		rx_last = last;
		rx_phy = phy;
		ok = 1'b0;
		for (int n = 0; n < 300 && !ok; n++) begin
			ok = (rx_ready === 1'b1);
			@(posedge ref_clk);
			#1;
		end
		if (!ok) begin
			n_errors++;
			wrap_up();
		end
	endtask

	task automatic frame_basic;
		lat = 2'h0;
		{rx_crc, rx_mcast, rx_port, rx_len, rx_type} = {2'b11, 2'b01, 11'h040,
			16'h0800};
		put(32'hA5A5_0001, 1'b0, 1'b0);
		put(32'hA5A5_0002, 1'b1, 1'b0);
		rx_valid = 1'b0;
		wait_for(0);
		`CHECK(u_host.mem[32'h0], 32'h6311_8040)
		`CHECK(u_host.mem[32'h104], 32'hA5A5_0002)
	endtask

	task automatic frame_chain;
		lat = 2'h3;
		{rx_crc, rx_mcast, rx_port, rx_len, rx_type} = {2'b00, 2'b10, 11'h5EF,
			16'h05DC};
		put(32'h5A5A_0001, 1'b0, 1'b1);
		put(32'h5A5A_0002, 1'b1, 1'b0);
		rx_valid = 1'b0;
		wait_for(0);
		`CHECK(u_host.mem[32'h40], 32'h4008_0000)
		`CHECK(u_host.mem[32'h80], 32'h222C_05EF)
		`CHECK(u_host.mem[32'h280], 32'h5A5A_0002)
	endtask

	task automatic frame_drop_skip;
		{rx_crc, rx_runt, rx_port, rx_len, rx_type} = {2'b01, 2'b00, 11'h010,
			16'h0000};
		put(32'h1111_0001, 1'b1, 1'b0);
		rx_runt = 1'b0;
		rx_type = 16'h0800;
		put(32'h2222_0001, 1'b1, 1'b0);
		rx_valid = 1'b0;
		wait_for(0);
		`CHECK(u_host.mem[32'hE0], 32'h6000_8010)
		`CHECK(u_host.mem[32'hC0], 32'h8000_0000)
		`CHECK(u_host.mem[32'h380], 32'h2222_0001)
	endtask

	task automatic wrap_suspend_release;
		wait_for(1);
		`CHECK(mem_addr, 32'h0000_0500)
		`CHECK(mem_req, 1'b0)
		u_host.mem[32'h700] = 32'h8000_0000;
		tx_addr = 32'h0000_0700;
		tx_rel = 1'b1;
		@(posedge ref_clk);
		#1;
		tx_rel = 1'b0;
		wait_for(2);
		`CHECK(u_host.mem[32'h700], 32'h0000_0000)
		wait_for(1);
		desc(32'h500, 32'h8, 32'h600, 32'h0);
		rx_poll = 1'b1;
		@(posedge ref_clk);
		#1;
		rx_poll = 1'b0;
		{pass_bad, rx_runt, rx_len} = {2'b11, 11'h008};
		put(32'h3333_0001, 1'b1, 1'b0);
		rx_valid = 1'b0;
		wait_for(0);
		`CHECK(u_host.mem[32'h500], 32'h6202_0008)
		`CHECK(u_host.mem[32'h600], 32'h3333_0001)
	endtask

	// main sequence: reset for three cycles, lay the list, then walk it
	initial begin
		{rst, rx_enable, rx_poll, pass_bad, rx_valid, rx_last, rx_phy} = 7'h40;
		{rx_crc, rx_runt, rx_mcast, tx_rel, rx_port, lat} = 8'h00;
		{rx_len, rx_type, rx_data, tx_addr} = 91'h0;
		repeat (3) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		desc(32'h0, 32'h8, 32'h100, 32'h40);
		desc(32'h40, 32'h4, 32'h200, 32'h80);
		desc(32'h80, 32'h8, 32'h280, 32'hC0);
		desc(32'hC0, 32'h0, 32'h300, 32'hE0);
		desc(32'hE0, 32'h0200_0008, 32'h380, 32'h400);
		u_host.mem[32'h500] = 32'h0;
		rx_enable = 1'b1;
		frame_basic();
		frame_chain();
		frame_drop_skip();
		wrap_suspend_release();
		wrap_up();
	end
endmodule // mac_dma_descriptor_fields_bench

`default_nettype wire
